// ---- proximity_readout_map.vh ----
// Constants for the proximity readout and interrupt block.
// Assumes a 100 MHz system clock; included by the design file only.
`ifndef PROXIMITY_READOUT_MAP_VH
`define PROXIMITY_READOUT_MAP_VH

// ==========================================================
// Bus address and command codes
`define BUS_ADDR 7'h60
`define CMD_CONF2 8'h03
`define CMD_LOWER_TH 8'h05
`define CMD_UPPER_TH 8'h06
`define CMD_CONF4 8'h08
`define CMD_COUNT 8'hf8
`define CMD_FLAGS 8'hf9
`define CMD_IDENT 8'hfa
`define CMD_CALRES 8'hfb

// ==========================================================
// Field positions
`define INTSEL_HI 3
`define INTSEL_LO 2
`define PERSIST_HI 5
`define PERSIST_LO 4
`define CAL_INT_EN_BIT 0
`define LP_EN_BIT 8
`define LP_PER_HI 10
`define LP_PER_LO 9
`define FLAG_CALDONE 13
`define FLAG_PROTECT 12
`define FLAG_APPROACH 10
`define FLAG_WITHDRAW 9
`define CAL_RUN_BIT 15
`define CAL_SUN_BIT 14
`define ADDR_OPT 2'h0

// ==========================================================
// Interrupt select codes
`define INTSEL_OFF 2'h0
`define INTSEL_LEVEL 2'h1
`define INTSEL_FIRST_HIGH 2'h2
`define INTSEL_NORMAL 2'h3

// ==========================================================
// Reset values
`define CONF2_RST 16'h0000
`define CONF4_RST 16'h0000
`define THRESH_RST 12'h000

// ==========================================================
// Timing
`define LP_BASE_MS 40
`define CLK_KHZ 100000
`endif

// ---- proximity_readout_interrupt.v ----
// Proximity readout, threshold interrupt and two-wire register slave.
// Assumes the front end delivers counts on clk; bus pins are asynchronous.
//
// Function
// - Count register holds 12-bit count, low byte bits 7:0, high 11:8.
// - Calibration finish sets flag bit 13 and can raise interrupt.
// - Entering protection mode sets flag bit 12.
// - Count above upper threshold sets approach flag bit 10.
// - Count below lower threshold sets withdraw flag bit 9.
// - Identity: device code low byte, address option 13:12, version 11:8.
// - Calibration result bit 15 is one while calibration runs.
// - Bit 14 set on sunlight protection during calibration.
// - Calibration value in low byte and bits 11:8.
// - All registers have defaults; bus usable right after reset.
// - First-high mode ignores lower crossings until first upper event.
// - First-high events stay pending until the flag register is read.
// - Normal mode signals both upper and lower threshold events.
// - Level mode: pin low at upper threshold, released below lower.
// - Persistence needs 1 to 4 consecutive samples past threshold.
// - Low-power mode starts measurements itself every selected period.
// - No threshold event while count lies between thresholds.
// - Lower threshold 12 bits at command 0x05, low then high byte.
// - Upper threshold 12 bits at command 0x06, low then high byte.
// - Low-power period bits 10:9: 40, 80, 160 or 320 ms.
`include "proximity_readout_map.vh"

module proximity_readout_interrupt #(
  parameter [31:0] LP_BASE_CYCLES = `LP_BASE_MS * `CLK_KHZ,
  parameter [7:0] DEV_CODE = 8'h5a, // Arbitrary value
  parameter [3:0] VERSION = 4'h3 // Arbitrary value
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Two-wire bus pins
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  // Interrupt pin, open drain
  output wire int_o,
  output wire int_oe,
  // Front end results
  input wire meas_valid,
  input wire [11:0] meas_count,
  input wire protect_enter,
  input wire cal_busy,
  input wire cal_done,
  input wire cal_sun,
  input wire [11:0] cal_value,
  // Measurement start request
  output wire measure_start
);
  // ========================================================
  // Bus states
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_ADDR = 5'h02;
  localparam [4:0] S_CMD = 5'h04;
  localparam [4:0] S_WDAT = 5'h08;
  localparam [4:0] S_RDAT = 5'h10;
  // Pin sync chains: bit 0 first stage, bit 2 edge history
  reg [2:0] scl_sync_ff, sda_sync_ff;
  reg [4:0] state_ff;
  reg [3:0] cnt_ff;
  reg [7:0] sh_ff, cmd_ff, wlow_ff;
  reg [15:0] rdw_ff, conf2_ff, conf4_ff, flags_ff;
  reg hi_ff, rw_ff, oe_ff, rclr_ff;
  reg [11:0] lower_th_ff, upper_th_ff, count_ff, calv_ff;
  reg sun_ff, busy_d_ff, near_ff, armed_ff, lvl_ff, int_oe_ff, start_ff;
  reg [2:0] hi_run_ff, lo_run_ff;
  reg [31:0] lp_cnt_ff;
  // ========================================================
  // Helpers
  function [2:0] sat_inc;
    input [2:0] v;
    begin
      sat_inc = (v == 3'h7) ? v : v + 3'h1;
    end
  endfunction
  function [15:0] rd_mux;
    input [7:0] c;
    begin
      case (c)
        `CMD_CONF2: rd_mux = conf2_ff;
        `CMD_LOWER_TH: rd_mux = {4'h0, lower_th_ff};
        `CMD_UPPER_TH: rd_mux = {4'h0, upper_th_ff};
        `CMD_CONF4: rd_mux = conf4_ff;
        `CMD_COUNT: rd_mux = {4'h0, count_ff};
        `CMD_FLAGS: rd_mux = flags_ff;
        `CMD_IDENT: rd_mux = {2'h0, `ADDR_OPT, VERSION, DEV_CODE};
        `CMD_CALRES: rd_mux = {cal_busy, sun_ff, 2'h0, calv_ff};
        default: rd_mux = 16'h0000;
      endcase
    end
  endfunction
  // ========================================================
  // Pin synchronisers and bus edge detection
  always @(posedge clk) begin
    if (rst) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
    end
  end
  wire scl_rise = scl_sync_ff[1] & ~scl_sync_ff[2];
  wire scl_fall = ~scl_sync_ff[1] & scl_sync_ff[2];
  wire scl_high = scl_sync_ff[1] & scl_sync_ff[2];
  wire bus_start = scl_high & sda_sync_ff[2] & ~sda_sync_ff[1];
  wire bus_stop = scl_high & ~sda_sync_ff[2] & sda_sync_ff[1];
  wire [7:0] tx_byte = hi_ff ? rdw_ff[15:8] : rdw_ff[7:0];
  wire [15:0] wr_word = {sh_ff, wlow_ff};
  // ========================================================
  // Bus slave: address, command, data bytes, register writes
  always @(posedge clk) begin
    if (rst) begin
      state_ff <= S_IDLE;
      cnt_ff <= 4'h0;
      cmd_ff <= 8'h00;
      hi_ff <= 1'b0;
      oe_ff <= 1'b0;
      rclr_ff <= 1'b0;
      conf2_ff <= `CONF2_RST;
      conf4_ff <= `CONF4_RST;
      lower_th_ff <= `THRESH_RST;
      upper_th_ff <= `THRESH_RST;
    end else begin
      rclr_ff <= 1'b0;
      if (bus_start) begin
        state_ff <= S_ADDR;
        cnt_ff <= 4'h0;
        oe_ff <= 1'b0;
        hi_ff <= 1'b0;
      end else if (bus_stop) begin
        state_ff <= S_IDLE;
        oe_ff <= 1'b0;
      end else if (state_ff != S_IDLE) begin
        if (scl_rise) begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff < 4'h8) begin
            sh_ff <= {sh_ff[6:0], sda_sync_ff[1]};
          end else if (state_ff == S_RDAT && sda_sync_ff[1]) begin
            state_ff <= S_IDLE; // Host refused further bytes
          end
        end else if (scl_fall) begin
          if (cnt_ff == 4'h8) begin
            // Byte done: acknowledge or finish a sent byte
            case (state_ff)
              S_ADDR: begin
                if (sh_ff[7:1] == `BUS_ADDR) begin
                  oe_ff <= 1'b1;
                  rw_ff <= sh_ff[0];
                  hi_ff <= 1'b0;
                  if (sh_ff[0]) begin
                    rdw_ff <= rd_mux(cmd_ff);
                  end
                end else begin
                  state_ff <= S_IDLE;
                end
              end
              S_CMD: begin
                cmd_ff <= sh_ff;
                oe_ff <= 1'b1;
                hi_ff <= 1'b0;
              end
              S_WDAT: begin
                oe_ff <= 1'b1;
                hi_ff <= ~hi_ff;
                if (!hi_ff) begin
                  wlow_ff <= sh_ff;
                end else begin
                  case (cmd_ff)
                    `CMD_CONF2: conf2_ff <= wr_word;
                    `CMD_LOWER_TH: lower_th_ff <= wr_word[11:0];
                    `CMD_UPPER_TH: upper_th_ff <= wr_word[11:0];
                    `CMD_CONF4: conf4_ff <= wr_word;
                    default: conf4_ff <= conf4_ff;
                  endcase
                end
              end
              S_RDAT: begin
                oe_ff <= 1'b0;
                hi_ff <= ~hi_ff;
                if (hi_ff && cmd_ff == `CMD_FLAGS) begin
                  rclr_ff <= 1'b1;
                end
              end
              default: oe_ff <= 1'b0;
            endcase
          end else if (cnt_ff == 4'h9) begin
            // Acknowledge slot over: release or send next byte
            cnt_ff <= 4'h0;
            oe_ff <= 1'b0;
            case (state_ff)
              S_ADDR: begin
                if (rw_ff) begin
                  state_ff <= S_RDAT;
                  oe_ff <= ~rdw_ff[7];
                end else begin
                  state_ff <= S_CMD;
                end
              end
              S_CMD: state_ff <= S_WDAT;
              S_RDAT: oe_ff <= ~tx_byte[7];
              default: state_ff <= state_ff;
            endcase
          end else if (state_ff == S_RDAT) begin
            oe_ff <= ~tx_byte[3'h7 - cnt_ff[2:0]];
          end
        end
      end
    end
  end
  // ========================================================
  // Threshold comparison with persistence and hysteresis
  wire [1:0] int_sel = conf2_ff[`INTSEL_HI:`INTSEL_LO];
  wire [2:0] need = {1'b0, conf2_ff[`PERSIST_HI:`PERSIST_LO]} + 3'h1;
  wire lvl_mode = (int_sel == `INTSEL_LEVEL);
  wire hit_hi = lvl_mode ? (meas_count >= upper_th_ff)
                         : (meas_count > upper_th_ff);
  wire hit_lo = meas_count < lower_th_ff;
  wire [2:0] hi_run_n = hit_hi ? sat_inc(hi_run_ff) : 3'h0;
  wire [2:0] lo_run_n = hit_lo ? sat_inc(lo_run_ff) : 3'h0;
  wire hi_ok = meas_valid & (hi_run_n >= need);
  wire lo_ok = meas_valid & (lo_run_n >= need);
  wire edge_mode = int_sel[1]; // First-high and normal codes share bit 1
  wire set_app = edge_mode & hi_ok & (~armed_ff | ~near_ff);
  wire wd_open = (int_sel == `INTSEL_NORMAL) ? (~armed_ff | near_ff)
                                              : (armed_ff & near_ff);
  wire set_wd = edge_mode & lo_ok & wd_open;
  always @(posedge clk) begin
    if (rst) begin
      count_ff <= 12'h000;
      hi_run_ff <= 3'h0;
      lo_run_ff <= 3'h0;
      near_ff <= 1'b0;
      armed_ff <= 1'b0;
      lvl_ff <= 1'b0;
    end else begin
      if (meas_valid) begin
        count_ff <= meas_count;
        hi_run_ff <= hi_run_n;
        lo_run_ff <= lo_run_n;
      end
      // Between thresholds nothing changes
      if (set_app) begin
        near_ff <= 1'b1;
        armed_ff <= 1'b1;
      end else if (set_wd) begin
        near_ff <= 1'b0;
        armed_ff <= 1'b1;
      end
      if (!lvl_mode) begin
        lvl_ff <= 1'b0;
      end else if (hi_ok) begin
        lvl_ff <= 1'b1;
      end else if (lo_ok) begin
        lvl_ff <= 1'b0;
      end
    end
  end
  // ========================================================
  // Event flags: read of the flag register clears, set wins
  wire [15:0] set_mask = ({15'h0, set_app} << `FLAG_APPROACH) |
                         ({15'h0, set_wd} << `FLAG_WITHDRAW) |
                         ({15'h0, protect_enter} << `FLAG_PROTECT) |
                         ({15'h0, cal_done} << `FLAG_CALDONE);
  wire [15:0] clr_mask = rclr_ff ? rdw_ff : 16'h0000;
  always @(posedge clk) begin
    if (rst) begin
      flags_ff <= 16'h0000;
    end else begin
      flags_ff <= (flags_ff & ~clr_mask) | set_mask;
    end
  end
  // ========================================================
  // Calibration result capture
  always @(posedge clk) begin
    if (rst) begin
      calv_ff <= 12'h000;
      sun_ff <= 1'b0;
      busy_d_ff <= 1'b0;
    end else begin
      busy_d_ff <= cal_busy;
      if (cal_done) begin
        calv_ff <= cal_value;
      end
      if (cal_busy && cal_sun) begin
        sun_ff <= 1'b1;
      end else if (cal_busy && !busy_d_ff) begin
        sun_ff <= 1'b0;
      end
    end
  end
  // ========================================================
  // Interrupt pin drive
  wire pending = flags_ff[`FLAG_APPROACH] | flags_ff[`FLAG_WITHDRAW] |
                 flags_ff[`FLAG_PROTECT] |
                 (flags_ff[`FLAG_CALDONE] & conf4_ff[`CAL_INT_EN_BIT]);
  always @(posedge clk) begin
    if (rst) begin
      int_oe_ff <= 1'b0;
    end else if (lvl_mode) begin
      int_oe_ff <= lvl_ff;
    end else begin
      int_oe_ff <= edge_mode & pending;
    end
  end
  // ========================================================
  // Low-power measurement timer
  wire lp_en = conf4_ff[`LP_EN_BIT];
  wire [1:0] lp_code = conf4_ff[`LP_PER_HI:`LP_PER_LO];
  wire [31:0] lp_period = LP_BASE_CYCLES << lp_code;
  always @(posedge clk) begin
    if (rst || !lp_en) begin
      lp_cnt_ff <= 32'h0;
      start_ff <= 1'b0;
    end else if (lp_cnt_ff >= lp_period - 32'h1) begin
      lp_cnt_ff <= 32'h0;
      start_ff <= 1'b1;
    end else begin
      lp_cnt_ff <= lp_cnt_ff + 32'h1;
      start_ff <= 1'b0;
    end
  end
  // ========================================================
  // Outputs
  assign sda_o = 1'b0;
  assign sda_oe = oe_ff;
  assign int_o = 1'b0;
  assign int_oe = int_oe_ff;
  assign measure_start = start_ff;
endmodule

// ---- host_model.sv ----
// Host model: two-wire bus master with pull-ups on both wires.
// Assumes the device pulls SDA low only through its enable output.
module host_model (
  // Clock
  input wire logic clk,
  // Device data pull-down enable
  input wire logic sda_oe,
  // Bus wires as seen by the device
  output wire logic scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // ======
  // Wired-and bus with pull-ups
  logic scl_h = 1'b1;
  logic sda_h = 1'b1;
  assign scl = scl_h;
  assign sda = sda_h & ~sda_oe;

  // Quarter of a bit time, ends just after an edge
  task automatic tk;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // One bit: data set mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    scl_h = 1'b0;
    tk;
    sda_h = b;
    tk;
    scl_h = 1'b1;
    tk;
    r = sda;
    tk;
  endtask

  // Start (a=1,b=0) or stop (a=0,b=1) while SCL high
  task automatic cond(input logic a, input logic b);
    scl_h = 1'b0;
    tk;
    sda_h = a;
    tk;
    scl_h = 1'b1;
    tk;
    sda_h = b;
    tk;
  endtask

  // Byte then acknowledge bit, most significant bit first
  task automatic xbyte(input logic [7:0] d, input logic ack,
                       output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack, nak);
  endtask

  // Register write: command, low byte, high byte
  task automatic wr(input logic [7:0] c, input logic [15:0] v,
                    output logic [15:0] nak);
    logic [7:0] q;
    nak = 16'h0000;
    cond(1'b1, 1'b0);
    xbyte({7'h60, 1'b0}, 1'b1, q, nak[0]);
    xbyte(c, 1'b1, q, nak[1]);
    xbyte(v[7:0], 1'b1, q, nak[2]);
    xbyte(v[15:8], 1'b1, q, nak[3]);
    cond(1'b0, 1'b1);
  endtask

  // Register read: command, repeated start, low then high byte
  task automatic rd(input logic [6:0] a, input logic [7:0] c,
                    output logic [15:0] v, output logic nak);
    logic n;
    cond(1'b1, 1'b0);
    xbyte({a, 1'b0}, 1'b1, v[7:0], nak);
    xbyte(c, 1'b1, v[7:0], n);
    cond(1'b1, 1'b0);
    xbyte({a, 1'b1}, 1'b1, v[7:0], n);
    xbyte(8'hff, 1'b0, v[7:0], n);
    xbyte(8'hff, 1'b1, v[15:8], n);
    cond(1'b0, 1'b1);
  endtask
endmodule

// ---- proximity_readout_interrupt_assertions.sv ----
// Checker for the proximity readout block, bound to its ports.
// Assumes one clock domain with a synchronous active-high reset.
module proximity_checker #(
  parameter [31:0] LP_BASE_CYCLES = 32'd50
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Bus pins
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe,
  // Interrupt pin
  input wire int_o,
  input wire int_oe,
  // Front end
  input wire meas_valid,
  input wire protect_enter,
  input wire cal_done,
  input wire measure_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ======
  // Cycles since the last measurement start
  reg [31:0] gap_ff;
  always @(posedge clk) begin
    if (rst || measure_start) begin
      gap_ff <= 32'h0;
    end else if (gap_ff != 32'hffffffff) begin
      gap_ff <= gap_ff + 32'h1;
    end
  end

  // Acknowledge or data bit held by the device
  sequence ack_hold_s;
    sda_oe [*4];
  endsequence

  // ======
  // Assertions
  pins_open_drain_a:
    assert property (!sda_o && !int_o) else $error("pin data not low");
  reset_quiet_a:
    assert property ($fell(rst) |-> !sda_oe && !int_oe && !measure_start)
    else $error("outputs active after reset");
  start_pulse_a:
    assert property (measure_start |=> !measure_start)
    else $error("measurement start longer than one cycle");
  lp_spacing_a:
    assert property (measure_start |-> gap_ff >= LP_BASE_CYCLES - 32'h1)
    else $error("measurement starts too close");
  int_cause_a:
    assert property ($rose(int_oe) |-> $past(meas_valid, 2) ||
      $past(protect_enter, 2) || $past(cal_done, 2))
    else $error("interrupt raised without event");
  int_release_a:
    assert property ($fell(int_oe) && !$past(rst) |->
      $past(meas_valid, 2) || !$past(scl_i, 2))
    else $error("interrupt released without cause");
  bus_hold_a:
    assert property (!$past(rst) && $changed(sda_oe) |->
      !scl_i && !$past(scl_i))
    else $error("data changed while clock high");
  ack_stand_a:
    assert property ($rose(sda_oe) |=> ack_hold_s)
    else $error("data bit too short");
endmodule

bind proximity_readout_interrupt proximity_checker #(
  .LP_BASE_CYCLES(LP_BASE_CYCLES)
) chk_i (.clk(clk), .rst(rst), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .int_o(int_o), .int_oe(int_oe),
  .meas_valid(meas_valid), .protect_enter(protect_enter),
  .cal_done(cal_done), .measure_start(measure_start));

// ---- proximity_readout_interrupt_tb.sv ----
// Testbench for the proximity readout block with a bus host model.
// Assumes host_model and the checker are compiled before it.
module proximity_readout_interrupt_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [31:0] LP_BASE = 32'd50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic meas_valid = 1'b0;
  logic [11:0] meas_count = 12'h000;
  logic protect_enter = 1'b0;
  logic cal_busy = 1'b0;
  logic cal_done = 1'b0;
  logic cal_sun = 1'b0;
  logic [11:0] cal_value = 12'h000;
  wire scl, sda, sda_o, sda_oe, int_o, int_oe, measure_start;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int cnt;
  logic [15:0] d;
  logic n;

  // ======
  // Device and host
  proximity_readout_interrupt #(.LP_BASE_CYCLES(LP_BASE),
    .DEV_CODE(8'hc3), .VERSION(4'h7)) uut (
    .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .int_o(int_o), .int_oe(int_oe),
    .meas_valid(meas_valid), .meas_count(meas_count),
    .protect_enter(protect_enter), .cal_busy(cal_busy),
    .cal_done(cal_done), .cal_sun(cal_sun), .cal_value(cal_value),
    .measure_start(measure_start));
  host_model host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  // Clock and hang guard
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      complete_run;
    end
  end

  // ======
  // Helpers
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] c, input logic [15:0] exp);
    host.rd(7'h60, c, d, n);
    chk(d, exp);
  endtask
  task automatic w(input logic [7:0] c, input logic [15:0] v);
    logic [15:0] nk;
    host.wr(c, v, nk);
    chk(nk, 16'h0000);
  endtask
  task automatic meas(input logic [11:0] v);
    meas_valid = 1'b1;
    meas_count = v;
    step(1);
    meas_valid = 1'b0;
    step(3);
  endtask
  task automatic do_reset;
    rst = 1'b1;
    step(8);
    rst = 1'b0;
    step(3);
  endtask
  task automatic complete_run;
    if (fails == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ======
  // Main sequence
  initial begin
    do_reset;
    chk({14'h0, sda_oe, int_oe}, 16'h0000);
    rchk(8'hfa, 16'h07c3);
    rchk(8'h03, 16'h0000);
    rchk(8'h10, 16'h0000);
    host.rd(7'h61, 8'hf8, d, n);
    chk({d[14:0], n}, 16'hffff);
    w(8'h05, 16'h0040);
    w(8'h06, 16'hf923);
    rchk(8'h05, 16'h0040);
    rchk(8'h06, 16'h0923);
    meas(12'h5a7);
    rchk(8'hf8, 16'h05a7);
    // First-high mode
    w(8'h03, 16'h0008);
    meas(12'h010);
    meas(12'h923);
    rchk(8'hf9, 16'h0000);
    meas(12'ha00);
    step(40);
    chk({15'h0, int_oe}, 16'h0001);
    rchk(8'hf9, 16'h0400);
    chk({15'h0, int_oe}, 16'h0000);
    // Normal mode
    w(8'h03, 16'h000c);
    meas(12'h5a7);
    meas(12'ha00);
    rchk(8'hf9, 16'h0000);
    meas(12'h03f);
    chk({15'h0, int_oe}, 16'h0001);
    rchk(8'hf9, 16'h0200);
    // Persistence of four samples
    w(8'h03, 16'h003c);
    for (int i = 0; i < 7; i++) meas(i == 3 ? 12'h5a7 : 12'ha00);
    rchk(8'hf9, 16'h0000);
    meas(12'ha00);
    rchk(8'hf9, 16'h0400);
    repeat (4) meas(12'h03f);
    rchk(8'hf9, 16'h0200);
    // Level mode
    w(8'h03, 16'h0004);
    meas(12'h923);
    chk({15'h0, int_oe}, 16'h0001);
    meas(12'h040);
    chk({15'h0, int_oe}, 16'h0001);
    meas(12'h03f);
    chk({15'h0, int_oe}, 16'h0000);
    // Protection and calibration
    w(8'h03, 16'h000c);
    w(8'h08, 16'h0001);
    protect_enter = 1'b1;
    step(1);
    protect_enter = 1'b0;
    step(3);
    chk({15'h0, int_oe}, 16'h0001);
    rchk(8'hf9, 16'h1000);
    cal_busy = 1'b1;
    step(2);
    cal_sun = 1'b1;
    step(1);
    cal_sun = 1'b0;
    rchk(8'hfb, 16'hc000);
    cal_value = 12'h9a5;
    cal_busy = 1'b0;
    cal_done = 1'b1;
    step(1);
    cal_done = 1'b0;
    step(3);
    chk({15'h0, int_oe}, 16'h0001);
    rchk(8'hfb, 16'h49a5);
    rchk(8'hf9, 16'h2000);
    // Low-power period codes
    for (int k = 0; k < 4; k++) begin
      w(8'h08, {5'h00, k[1:0], 9'h100});
      cnt = 0;
      while (measure_start !== 1'b1 && cnt < 1000) begin
        step(1);
        cnt++;
      end
      step(1);
      cnt = 1;
      while (measure_start !== 1'b1 && cnt < 1000) begin
        step(1);
        cnt++;
      end
      chk(cnt[15:0], LP_BASE[15:0] << k);
    end
    // Second reset restores defaults
    do_reset;
    rchk(8'h08, 16'h0000);
    rchk(8'hf9, 16'h0000);
    complete_run;
  end
endmodule
